// file: design/ec_cam.sv
// eight-lobe electronic cam with direct i/o and override setup
//
// Notes on behaviour
// - eight lobe comparators, each with its own on and off count.
// - a lobe is active only while the counter lies inside its range.
// - on at low set-point, off at high; inversion swaps this.
// - per-output polarity picks on or off inside the range.
// - maximum count below high set-point acts as the high set-point.
// - maximum count below low set-point keeps the lobe inactive.
// - pins 1-4 are A, B, marker, marker disable; 5-8 general.
// - input read always returns the eight input pin levels.
// - a read-only byte shows the driven state of all outputs.
// - direct write latches seven lines driving output pins 1-7.
// - cam signals take priority over direct lines on output pins.
// - direct line usable only when that pin's lobe is merged away.
// - override bit picks runtime bits over the preloaded setup.
// - override gives merge bits, marker polarity, phase, 1 MHz select.
// - a control bit holds the counter cleared asynchronously.
// - override gives one polarity bit per output.
// - override gives threshold, filter and prescaler fields.
// - a read-only word reports option number three.
// - counter value readable as low word then high word.
// - the counter is 24 bits, any length up to 16,777,216.
// - quadrature counts every edge of A or B alone, up when A leads B.
// - merged lobes appear on the highest channel of the group.
// - marker ignored while marker disable is high.
`timescale 1ns/10ps
`include "ec_defs.svh"
module ec_cam #(
    parameter int         LOBES       = 8,
    parameter logic [6:0] PRE_MERGE   = 7'h00,
    parameter logic [7:0] PRE_POL_NEG = 8'h00,
    parameter logic       PRE_MPOL    = 1'b0,
    parameter logic       PRE_MPHS    = 1'b0,
    parameter logic       PRE_INTCLK  = 1'b0,
    parameter logic [1:0] PRE_PS      = 2'h0,
    parameter logic [1:0] PRE_VIN     = 2'h0,
    parameter logic [1:0] PRE_FILT    = 2'h0
) (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_nrst,
    // register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    // connector pins
    input  wire logic [7:0]  i_in_pins,
    output logic      [7:0]  o_out_pins,
    // input conditioning selects
    output logic      [1:0]  o_vin_sel,
    output logic      [1:0]  o_filt_sel
);
    if (LOBES != 8) begin : g_bad_lobes
        $error("ec_cam: merge tree serves eight lobes only");
    end

    localparam int TICK_DIV = `EC_CLK_HZ / `EC_TICK_HZ;
    localparam logic [4:0] TICK_LAST = 5'(TICK_DIV - 1);
    // merge k feeds this channel index
    localparam logic [2:0] TGT [7] = '{3'h1, 3'h3, 3'h3, 3'h7,
                                      3'h5, 3'h7, 3'h7};

    // ==========================================================
    // pin synchronisers
    logic [7:0] in_meta;
    logic [7:0] in_sync;
    logic [7:0] in_prev;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            in_meta <= 8'h00;
            in_sync <= 8'h00;
            in_prev <= 8'h00;
        end else begin
            in_meta <= i_in_pins;
            in_sync <= in_meta;
            in_prev <= in_sync;
        end
    end
    wire enc_a  = in_sync[0];
    wire enc_b  = in_sync[1];
    wire mark   = in_sync[2];
    wire mk_dis = in_sync[3];

    // ==========================================================
    // control registers
    logic [7:0]  direct;
    logic [15:0] cfga;
    logic [15:0] cfgb;
    wire  wr_dir  = i_wr && i_addr == `EC_A_DIRECT;
    wire  wr_cfga = i_wr && i_addr == `EC_A_CFGA;
    wire  wr_cfgb = i_wr && i_addr == `EC_A_CFGB;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            direct <= 8'h00;
            cfga   <= 16'h0000;
            cfgb   <= 16'h0000;
        end else begin
            if (wr_dir)
                direct <= i_wdata[7:0];
            if (wr_cfga)
                cfga <= i_wdata;
            if (wr_cfgb)
                cfgb <= i_wdata;
        end
    end

    // configuration source select
    wire       ovr   = direct[`EC_DIR_OVR];
    wire [6:0] merge = ovr ? cfga[6:0] : PRE_MERGE;
    wire [7:0] polng = ovr ? cfgb[7:0] : PRE_POL_NEG;
    wire       mpol  = ovr ? cfga[`EC_CFGA_MPOL] : PRE_MPOL;
    wire       mphs  = ovr ? cfga[`EC_CFGA_MPHS] : PRE_MPHS;
    wire       intck = ovr ? cfga[`EC_CFGA_1MHZ] : PRE_INTCLK;
    wire [1:0] ps    = ovr ? cfgb[`EC_CFGB_PS +: 2] : PRE_PS;
    wire [1:0] vin   = ovr ? cfgb[`EC_CFGB_VIN +: 2] : PRE_VIN;
    wire [1:0] filt  = ovr ? cfgb[`EC_CFGB_FILT +: 2] : PRE_FILT;
    wire ec_pkg::ec_src_e src =
        intck ? ec_pkg::EC_SRC_INT : ec_pkg::EC_SRC_ENC;

    // counter clear acts regardless of the override bit
    wire cnt_clr  = cfga[`EC_CFGA_CLR];
    wire cnt_rstn = i_nrst & ~cnt_clr;

    // ==========================================================
    // set-point store
    logic [`EC_SP_WORDS*16-1:0] sp_words;
    wire [7:0] sp_off = i_addr - `EC_A_SP_BASE;
    wire sp_hit = i_addr >= `EC_A_SP_BASE &&
                  sp_off < 8'(`EC_SP_WORDS);
    ec_spmem #(
        .DEPTH (`EC_SP_WORDS),
        .WIDTH (16)
    ) u_mem (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_we      (i_wr && sp_hit),
        .i_waddr   (sp_off[5:0]),
        .i_wdata   (i_wdata),
        .o_words   (sp_words)
    );
    wire [31:0] rev_len = sp_words[`EC_REV_IDX*16 +: 32];
    // zero or oversize length falls back to the full 24-bit turn
    wire ec_pkg::ec_count_t max_cnt =
        (rev_len == 32'h0 || rev_len > `EC_FULL_REV) ?
        `EC_CNT_ALL : 24'(rev_len - 32'h1);

    // ==========================================================
    // count sources
    wire da = enc_a ^ in_prev[0];
    wire db = enc_b ^ in_prev[1];
    // both edges at once are a lost phase and do not count
    wire q_step = da ^ db;
    wire q_up   = enc_a ^ in_prev[1];

    logic [4:0] tick_cnt;
    logic [9:0] dec_cnt;
    wire  t1m = tick_cnt == TICK_LAST;
    wire [9:0] dec_last = (ps == 2'h0) ? 10'h000 :
                          (ps == 2'h1) ? `EC_DIV_100K :
                          (ps == 2'h2) ? `EC_DIV_10K : `EC_DIV_1K;
    wire  itick = t1m && dec_cnt == dec_last;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tick_cnt <= 5'h00;
            dec_cnt  <= 10'h000;
        end else begin
            tick_cnt <= t1m ? 5'h00 : tick_cnt + 5'h01;
            if (itick)
                dec_cnt <= 10'h000;
            else if (t1m)
                dec_cnt <= dec_cnt + 10'h001;
        end
    end

    // marker: qualified level, restarts the count on its rising edge while the encoder is the count source
    logic mk_q;
    wire  mk_lvl = (mark ^ mpol) & (enc_b ^ mphs) & ~mk_dis;
    wire  mk_hit = mk_lvl & ~mk_q & (src == ec_pkg::EC_SRC_ENC);
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst)
            mk_q <= 1'b0;
        else
            mk_q <= mk_lvl;
    end

    wire step = (src == ec_pkg::EC_SRC_INT) ? itick : q_step;
    wire up   = (src == ec_pkg::EC_SRC_INT) | q_up;

    // ==========================================================
    // revolution counter
    ec_pkg::ec_count_t cnt;
    ec_pkg::ec_count_t next_cnt;
    always_comb begin
        next_cnt = cnt;
        if (mk_hit)
            next_cnt = 24'h00_0000;
        else if (step && up)
            next_cnt = (cnt >= max_cnt) ? 24'h00_0000
                                        : cnt + 24'h00_0001;
        else if (step)
            next_cnt = (cnt == 24'h00_0000) ? max_cnt
                                            : cnt - 24'h00_0001;
    end
    always_ff @(posedge i_sys_clk or negedge cnt_rstn) begin
        if (!cnt_rstn)
            cnt <= 24'h00_0000;
        else
            cnt <= next_cnt;
    end

    // ==========================================================
    // lobe comparators
    wire [31:0] cnt32 = {8'h00, cnt};
    logic [7:0] in_rng;
    logic [7:0] lobe;
    genvar g;
    generate
        for (g = 0; g < LOBES; g++) begin : g_lobe
            wire [31:0] lo = sp_words[g*64 +: 32];
            wire [31:0] hi = sp_words[g*64+32 +: 32];
            wire [31:0] eff_hi = ({8'h00, max_cnt} < hi) ?
                                 {8'h00, max_cnt} : hi;
            wire reach = {8'h00, max_cnt} >= lo;
            assign in_rng[g] = reach && cnt32 >= lo &&
                               cnt32 < eff_hi;
            assign lobe[g] = in_rng[g] ^ polng[g];
        end
    endgenerate

    // merge tree: each merge folds into a higher channel
    logic [7:0] cam_sig;
    always_comb begin
        cam_sig = lobe;
        for (int k = 0; k < 7; k++) begin
            if (merge[k])
                cam_sig[TGT[k]] = cam_sig[TGT[k]] |
                                  cam_sig[k];
        end
    end

    // pin multiplexer
    wire [7:0] next_out = {cam_sig[7],
                           (merge & direct[6:0]) |
                           (~merge & cam_sig[6:0])};

    // ==========================================================
    // read path
    wire [15:0] sp_rd = sp_words[sp_off[5:0]*16 +: 16];
    wire [15:0] rd_mux =
        (i_addr == `EC_A_INPUTS)   ? {8'h00, in_sync} :
        (i_addr == `EC_A_OUTSTATE) ? {8'h00, o_out_pins} :
        (i_addr == `EC_A_DIRECT)   ? {8'h00, direct} :
        (i_addr == `EC_A_CFGA)     ? cfga :
        (i_addr == `EC_A_CFGB)     ? cfgb :
        (i_addr == `EC_A_OPTION)   ? `EC_OPTION_NUM :
        (i_addr == `EC_A_CNT_LO)   ? cnt[15:0] :
        (i_addr == `EC_A_CNT_HI)   ? {8'h00, cnt[23:16]} :
        sp_hit                     ? sp_rd : 16'h0000;

    // ==========================================================
    // registered outputs
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata    <= 16'h0000;
            o_out_pins <= 8'h00;
            o_vin_sel  <= 2'h0;
            o_filt_sel <= 2'h0;
        end else begin
            o_rdata    <= i_rd ? rd_mux : 16'h0000;
            o_out_pins <= next_out;
            o_vin_sel  <= vin;
            o_filt_sel <= filt;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);

    property p_option;
        i_rd && i_addr == `EC_A_OPTION |=> o_rdata == 16'h0003;
    endproperty
    a_option: assert property (p_option)
        else $error("option word not three");

    property p_inputs;
        i_rd && i_addr == `EC_A_INPUTS
            |=> o_rdata[7:0] == $past(in_sync);
    endproperty
    a_inputs: assert property (p_inputs)
        else $error("input read mismatch");

    property p_outstate;
        i_rd && i_addr == `EC_A_OUTSTATE
            |=> o_rdata[7:0] == $past(o_out_pins);
    endproperty
    a_outstate: assert property (p_outstate)
        else $error("output state read mismatch");

    property p_clear;
        cnt_clr |-> cnt == 24'h00_0000;
    endproperty
    a_clear: assert property (p_clear)
        else $error("counter not held clear");

    property p_wrap_up;
        cnt_rstn && !mk_hit && step && up && cnt == max_cnt
            ##1 cnt_rstn |-> cnt == 24'h00_0000;
    endproperty
    a_wrap_up: assert property (p_wrap_up)
        else $error("counter failed to wrap up");

    property p_step_up;
        cnt_rstn && !mk_hit && step && up && cnt < max_cnt
            ##1 cnt_rstn |-> cnt == $past(cnt) + 24'h00_0001;
    endproperty
    a_step_up: assert property (p_step_up)
        else $error("counter did not step up");

    property p_pin8;
        ##1 o_out_pins[7] == $past(cam_sig[7]);
    endproperty
    a_pin8: assert property (p_pin8)
        else $error("pin eight not cam driven");

    property p_direct1;
        merge[0] |=> o_out_pins[0] == $past(direct[0]);
    endproperty
    a_direct1: assert property (p_direct1)
        else $error("freed pin one not direct");

    property p_unreach;
        {8'h00, max_cnt} < sp_words[31:0] |-> !in_rng[0];
    endproperty
    a_unreach: assert property (p_unreach)
        else $error("unreachable lobe active");

    c_wrap: cover property (step && up && cnt == max_cnt);
    c_marker: cover property (mk_hit);
    c_direct: cover property (merge[0] && direct[0]);
    c_lobe: cover property (in_rng[0] ##1 !in_rng[0]);
endmodule

// file: design/ec_defs.svh
// constants for the electronic cam block
`ifndef EC_DEFS_SVH
`define EC_DEFS_SVH
// ==========================================================
// register addresses (word index on the plain port)
`define EC_A_INPUTS   8'h00
`define EC_A_OUTSTATE 8'h01
`define EC_A_DIRECT   8'h02
`define EC_A_CFGA     8'h03
`define EC_A_CFGB     8'h04
`define EC_A_OPTION   8'h05
`define EC_A_CNT_LO   8'h06
`define EC_A_CNT_HI   8'h07
`define EC_A_SP_BASE  8'h10
// ==========================================================
// field positions
`define EC_DIR_OVR    7
`define EC_CFGA_MPOL  8
`define EC_CFGA_MPHS  9
`define EC_CFGA_1MHZ  10
`define EC_CFGA_CLR   11
`define EC_CFGB_VIN   8
`define EC_CFGB_FILT  10
`define EC_CFGB_PS    12
// ==========================================================
// values
`define EC_OPTION_NUM 16'h0003
`define EC_SP_WORDS   34
`define EC_REV_IDX    32
`define EC_FULL_REV   32'h0100_0000
`define EC_CNT_ALL    24'hFF_FFFF
// ==========================================================
// timing
`define EC_CLK_HZ     20000000
`define EC_TICK_HZ    1000000
// last decade count of each slower internal rate
`define EC_DIV_100K   10'h009
`define EC_DIV_10K    10'h063
`define EC_DIV_1K     10'h3E7
`endif

// file: design/ec_pkg.sv
// types shared by the electronic cam block
package ec_pkg;
    typedef logic [23:0] ec_count_t;
    typedef enum logic {EC_SRC_ENC, EC_SRC_INT} ec_src_e;
endpackage

// file: design/ec_spmem.sv
// set-point and revolution-length word store
`timescale 1ns/10ps
module ec_spmem #(
    parameter int DEPTH = 34,
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_nrst,
    // write port
    input  wire logic                   i_we,
    input  wire logic [5:0]             i_waddr,
    input  wire logic [WIDTH-1:0]       i_wdata,
    // all stored words, each straight from its register
    output logic      [DEPTH*WIDTH-1:0] o_words
);
    // six address bits reach 64 words at most
    if (DEPTH > 64 || DEPTH < 1) begin : g_bad_depth
        $error("ec_spmem: depth out of range");
    end

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_word
            always_ff @(posedge i_sys_clk or negedge i_nrst) begin
                if (!i_nrst)
                    o_words[g*WIDTH +: WIDTH] <= '0;
                else if (i_we && i_waddr == 6'(g))
                    o_words[g*WIDTH +: WIDTH] <= i_wdata;
            end
        end
    endgenerate
endmodule

// file: verification/ec_enc_model.sv
// quadrature encoder model driving the cam block's input pins
`timescale 1ns/10ps
// ==========================================================
// encoder model
module ec_enc_model (
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_nrst,
    // step commands from the bench
    input  wire logic       i_up,
    input  wire logic       i_dn,
    // marker and marker disable levels set by the bench
    input  wire logic       i_mark,
    input  wire logic       i_mdis,
    // encoder lines: a, b, marker, marker disable
    output logic      [3:0] o_enc
);
    logic [1:0] phase;

    // gray order, so only one line moves per step
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            phase <= 2'h0;
        end else if (i_up) begin
            phase <= phase + 2'h1;
        end else if (i_dn) begin
            phase <= phase - 2'h1;
        end
    end

    // a rises while b is low when stepping up
    assign o_enc[0]   = (phase == 2'h1) || (phase == 2'h2);
    assign o_enc[1]   = phase[1];
    // marker lines pass straight through, bench keeps them off edges
    assign o_enc[3:2] = {i_mdis, i_mark};
endmodule

// file: verification/ec_cam_bench.sv
// self-checking bench for the electronic cam block
`timescale 1ns/10ps
`include "ec_defs.svh"
module ec_cam_bench;
    logic        i_sys_clk;
    logic        i_nrst;
    logic        i_wr;
    logic        i_rd;
    logic        up;
    logic        dn;
    logic        mark;
    logic        mdis;
    logic [7:0]  i_addr;
    logic [7:0]  i_in_pins;
    logic [7:0]  o_out_pins;
    logic [15:0] i_wdata;
    logic [15:0] o_rdata;
    logic [15:0] rdv;
    logic [3:0]  enc;
    logic [3:0]  gp;
    logic [1:0]  o_vin_sel;
    logic [1:0]  o_filt_sel;
    int          error_cnt;
    int          check_count;
    int          cycles;

    assign i_in_pins = {gp, enc};

    ec_cam i_ec_cam (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_in_pins(i_in_pins), .o_out_pins(o_out_pins),
        .o_vin_sel(o_vin_sel), .o_filt_sel(o_filt_sel));

    ec_enc_model i_ec_enc_model (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
        .i_up(up), .i_dn(dn), .i_mark(mark), .i_mdis(mdis), .o_enc(enc));

    // ==========================================================
    // clock and hang guard
    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end

    // whole run is under a thousand cycles
    always @(posedge i_sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            end_sim();
        end
    end

    // ==========================================================
    // helpers
    task automatic end_sim();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge i_sys_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd   <= 1'b0;
        #1;
        rdv = o_rdata;
    endtask

    task automatic settle();
        repeat (2) @(posedge i_sys_clk);
        #1;
    endtask

    // sync, decode, count and output flops all lie inside five edges
    task automatic step(input logic u);
        @(posedge i_sys_clk);
        up <= u;
        dn <= !u;
        @(posedge i_sys_clk);
        up <= 1'b0;
        dn <= 1'b0;
        repeat (5) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic sp(input logic [7:0] b, input logic [31:0] lo,
                      input logic [31:0] hi);
        wr(b, lo[15:0]);
        wr(b + 8'h01, lo[31:16]);
        wr(b + 8'h02, hi[15:0]);
        wr(b + 8'h03, hi[31:16]);
    endtask

    // lobe 1 on 2..4, lobe 2 on 3..6 (high clipped to max 7)
    function automatic logic [15:0] cam_exp(input int c);
        cam_exp = {14'h0000, c >= 3 && c < 7, c >= 2 && c < 5};
    endfunction

    // ==========================================================
    // scenarios
    task automatic t_regs();
        rd(`EC_A_OPTION);
        chk(rdv, `EC_OPTION_NUM, "option");
        wr(`EC_A_OPTION, 16'h00FF);
        rd(`EC_A_OPTION);
        chk(rdv, `EC_OPTION_NUM, "ro write");
        rd(8'hEE);
        chk(rdv, 16'h0000, "unmapped");
        @(posedge i_sys_clk);
        gp <= 4'hA;
        repeat (4) @(posedge i_sys_clk);
        rd(`EC_A_INPUTS);
        chk(rdv, {8'h00, i_in_pins}, "inputs");
    endtask

    task automatic t_walk();
        sp(8'h10, 32'h0000_0002, 32'h0000_0005);
        sp(8'h14, 32'h0000_0003, 32'h0000_0100);
        sp(8'h18, 32'h0000_0014, 32'h0000_001E);
        wr(8'h30, 16'h0008);
        wr(8'h31, 16'h0000);
        wr(`EC_A_CFGA, 16'h0800);
        rd(`EC_A_CNT_LO);
        chk(rdv, 16'h0000, "clear");
        wr(`EC_A_CFGA, 16'h0000);
        for (int c = 0; c < 9; c++) begin
            rd(`EC_A_CNT_LO);
            chk(rdv, 16'(c % 8), "count up");
            chk(16'(o_out_pins), cam_exp(c % 8), "cam");
            step(1'b1);
        end
        step(1'b0);
        step(1'b0);
        rd(`EC_A_CNT_LO);
        chk(rdv, 16'h0007, "wrap down");
        rd(`EC_A_CNT_HI);
        chk(rdv, 16'h0000, "count high");
    endtask

    task automatic t_ovr();
        wr(`EC_A_CFGA, 16'h0800);
        wr(`EC_A_CFGA, 16'h0001);
        step(1'b1);
        step(1'b1);
        wr(`EC_A_CFGB, 16'h0601);
        settle();
        chk(16'(o_out_pins), 16'h0001, "preloaded");
        chk({12'h000, o_filt_sel, o_vin_sel}, 16'h0000, "cond off");
        wr(`EC_A_DIRECT, 16'h0083);
        settle();
        chk(16'(o_out_pins), 16'h0001, "direct");
        chk({12'h000, o_filt_sel, o_vin_sel}, 16'h0006, "cond on");
        step(1'b1);
        chk(16'(o_out_pins), 16'h0003, "merged");
        rd(`EC_A_OUTSTATE);
        chk(rdv, 16'h0003, "out state");
        wr(`EC_A_DIRECT, 16'h0082);
        settle();
        chk(16'(o_out_pins), 16'h0002, "direct off");
    endtask

    // count 3 from t_ovr, encoder left with b high after one more step
    task automatic t_mark();
        step(1'b1);
        @(posedge i_sys_clk);
        mark <= 1'b1;
        settle();
        settle();
        rd(`EC_A_CNT_LO);
        chk(rdv, 16'h0004, "marker masked");
        @(posedge i_sys_clk);
        mdis <= 1'b0;
        settle();
        settle();
        rd(`EC_A_CNT_LO);
        chk(rdv, 16'h0000, "marker home");
        @(posedge i_sys_clk);
        mark <= 1'b0;
        mdis <= 1'b1;
    endtask

    // windows of exactly three tick periods between the two samples
    task automatic t_int();
        int v0;
        wr(`EC_A_CFGA, 16'h0401);
        rd(`EC_A_CNT_LO);
        v0 = rdv;
        repeat (58) @(posedge i_sys_clk);
        rd(`EC_A_CNT_LO);
        chk(rdv, 16'((v0 + 3) % 8), "1 MHz ticks");
        wr(`EC_A_CFGB, 16'h1601);
        rd(`EC_A_CNT_LO);
        v0 = rdv;
        repeat (598) @(posedge i_sys_clk);
        rd(`EC_A_CNT_LO);
        chk(rdv, 16'((v0 + 3) % 8), "100 kHz ticks");
    endtask

    // ==========================================================
    // main sequence
    initial begin
        i_nrst      = 1'b0;
        i_wr        = 1'b0;
        i_rd        = 1'b0;
        i_addr      = 8'h00;
        i_wdata     = 16'h0000;
        up          = 1'b0;
        dn          = 1'b0;
        mark        = 1'b0;
        mdis        = 1'b1;
        gp          = 4'h0;
        error_cnt   = 0;
        check_count = 0;
        cycles      = 0;
        repeat (8) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        t_regs();
        t_walk();
        t_ovr();
        t_mark();
        t_int();
        end_sim();
    end
endmodule
